// File: shared/config_loader_pkg.sv
// Constants and types shared by the three-wire configuration loader
package config_loader_pkg;

	localparam int WORD_WIDTH    = 24;
	localparam int CTRL_WIDTH    = 2;
	localparam int LATCH_COUNT   = 4;
	localparam int CTRL_LSB      = 0;
	localparam int MON_SEL_WIDTH = 2;

	localparam logic [WORD_WIDTH-1:0] WORD_RESET = 24'h00_0000;

	// Monitor output source selection codes
	localparam logic [MON_SEL_WIDTH-1:0] MON_SEL_LOCK = 2'h0;
	localparam logic [MON_SEL_WIDTH-1:0] MON_SEL_RF   = 2'h1;
	localparam logic [MON_SEL_WIDTH-1:0] MON_SEL_REF  = 2'h2;
	localparam logic [MON_SEL_WIDTH-1:0] MON_SEL_LOW  = 2'h3;

	typedef logic [WORD_WIDTH-1:0] word_type;

endpackage : config_loader_pkg

// File: hdl/pin_sync.sv
// Two-flop synchroniser for a group of asynchronous pin inputs
`timescale 1ns/100ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock, reset, enable
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	input  wire logic             clk_en,
	// Pins in, synchronised out
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_sync_out
);

	logic [WIDTH-1:0] meta_reg;

	// First stage read only by the second stage
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			meta_reg     <= '0;
			pin_sync_out <= '0;
		end else if (clk_en) begin
			meta_reg     <= pin_in;
			pin_sync_out <= meta_reg;
		end
	end

endmodule : pin_sync

// File: hdl/three_wire_config_loader.sv
// Three-wire write-only configuration port with four latches and monitor mux
`timescale 1ns/100ps
module three_wire_config_loader
#(
	parameter int MON_SEL_LSB = 2,
	parameter int PD_BIT_LSB  = 20,
	parameter int PD_LATCH    = 0
) (
	// Clock, reset, enable
	input  wire logic                      core_clk,
	input  wire logic                      sys_rst,
	input  wire logic                      clk_en,
	// Serial pins from the host
	input  wire logic                      serial_clk,
	input  wire logic                      serial_data,
	input  wire logic                      load_strobe,
	input  wire logic                      chip_enable,
	// Sources for the monitor output
	input  wire logic                      lock_detect,
	input  wire logic                      rf_scaled,
	input  wire logic                      ref_scaled,
	// Outputs
	output logic                           monitor_output,
	output logic                           powered_up,
	output logic                           cp_enable,
	output logic [config_loader_pkg::LATCH_COUNT*config_loader_pkg::WORD_WIDTH-1:0] latch_bus
);

	import config_loader_pkg::*;

	// ********************************************************
	// Pin synchronisation
	// ********************************************************
	localparam int PIN_COUNT = 7;
	logic [PIN_COUNT-1:0] pins_sync;
	logic                 sclk_s;
	logic                 sdata_s;
	logic                 strobe_s;
	logic                 ce_s;
	logic                 lock_s;
	logic                 rf_s;
	logic                 ref_s;

	pin_sync #(
		.WIDTH (PIN_COUNT)
	) pin_sync_inst (
		.core_clk     (core_clk),
		.sys_rst      (sys_rst),
		.clk_en       (clk_en),
		.pin_in       ({ref_scaled, rf_scaled, lock_detect, chip_enable,
		                load_strobe, serial_data, serial_clk}),
		.pin_sync_out (pins_sync)
	);

	localparam int PIN_SCLK   = 0;
	localparam int PIN_SDATA  = 1;
	localparam int PIN_STROBE = 2;
	localparam int PIN_CE     = 3;
	localparam int PIN_LOCK   = 4;
	localparam int PIN_RF     = 5;
	localparam int PIN_REF    = 6;

	assign sclk_s   = pins_sync[PIN_SCLK];
	assign sdata_s  = pins_sync[PIN_SDATA];
	assign strobe_s = pins_sync[PIN_STROBE];
	assign ce_s     = pins_sync[PIN_CE];
	assign lock_s   = pins_sync[PIN_LOCK];
	assign rf_s     = pins_sync[PIN_RF];
	assign ref_s    = pins_sync[PIN_REF];

	// ********************************************************
	// Edge detection
	// ********************************************************
	logic sclk_prev_reg;
	logic strobe_prev_reg;
	logic sclk_rise;
	logic strobe_rise;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sclk_prev_reg <= 1'b0;
		end else if (clk_en) begin
			sclk_prev_reg <= sclk_s;
		end
	end

	// Both pins idle low, so a low reset value gives no false edge
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			strobe_prev_reg <= 1'b0;
		end else if (clk_en) begin
			strobe_prev_reg <= strobe_s;
		end
	end

	assign sclk_rise   = sclk_s & ~sclk_prev_reg;
	assign strobe_rise = strobe_s & ~strobe_prev_reg;

	// ********************************************************
	// Shift register
	// ********************************************************
	word_type shift_reg;
	word_type shift_next;

	always_comb begin
		shift_next = {shift_reg[WORD_WIDTH-2:0], sdata_s};
	end

	// Data is sampled alongside the clock, so host setup time covers the sync delay
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			shift_reg <= WORD_RESET;
		end else if (clk_en && sclk_rise) begin
			shift_reg <= shift_next;
		end
	end

	// ********************************************************
	// Latches
	// ********************************************************
	logic [CTRL_WIDTH-1:0] ctrl_sel;
	word_type              latch_reg [LATCH_COUNT];
	word_type              latch_out_reg [LATCH_COUNT];
	logic [LATCH_COUNT-1:0] latch_load;

	assign ctrl_sel = shift_reg[CTRL_LSB +: CTRL_WIDTH];

	generate
		for (genvar i = 0; i < LATCH_COUNT; i++) begin : g_load
			assign latch_load[i] = strobe_rise && (ctrl_sel == CTRL_WIDTH'(i));
		end
	endgenerate

	generate
		for (genvar i = 0; i < LATCH_COUNT; i++) begin : g_latch
			always_ff @(posedge core_clk) begin
				if (sys_rst) begin
					latch_reg[i] <= WORD_RESET;
				end else if (clk_en && latch_load[i]) begin
					latch_reg[i] <= shift_reg;
				end
			end
		end
	endgenerate

	// ********************************************************
	// Latch outputs
	// ********************************************************

	// One cycle of extra latency keeps every output straight off a flop
	generate
		for (genvar i = 0; i < LATCH_COUNT; i++) begin : g_out
			always_ff @(posedge core_clk) begin
				if (sys_rst) begin
					latch_out_reg[i] <= WORD_RESET;
				end else if (clk_en) begin
					latch_out_reg[i] <= latch_reg[i];
				end
			end
			assign latch_bus[i*WORD_WIDTH +: WORD_WIDTH] = latch_out_reg[i];
		end
	endgenerate

	// ********************************************************
	// Power control
	// ********************************************************
	localparam int PD_BIT_WIDTH = 2;
	logic pd_bits_clear;

	// Latched word only steers power when chip enable allows it
	assign pd_bits_clear = (latch_reg[PD_LATCH][PD_BIT_LSB +: PD_BIT_WIDTH] == '0);

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			powered_up <= 1'b0;
		end else if (clk_en) begin
			powered_up <= ce_s & pd_bits_clear;
		end
	end

	// ********************************************************
	// Charge pump enable
	// ********************************************************
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cp_enable <= 1'b0;
		end else if (clk_en) begin
			cp_enable <= ce_s & pd_bits_clear;
		end
	end

	// ********************************************************
	// Monitor output
	// ********************************************************
	logic [MON_SEL_WIDTH-1:0] mon_sel;
	logic                     monitor_next;

	assign mon_sel = latch_reg[PD_LATCH][MON_SEL_LSB +: MON_SEL_WIDTH];

	// Scaled clocks pass through sync, so only slow sources survive intact
	always_comb begin
		case (mon_sel)
			MON_SEL_LOCK: monitor_next = lock_s;
			MON_SEL_RF:   monitor_next = rf_s;
			MON_SEL_REF:  monitor_next = ref_s;
			MON_SEL_LOW:  monitor_next = 1'b0;
			default:      monitor_next = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			monitor_output <= 1'b0;
		end else if (clk_en) begin
			monitor_output <= monitor_next;
		end
	end

endmodule : three_wire_config_loader

// File: tb/serial_host_model.sv
// Host model shifting words into the loader
`timescale 1ns/100ps
module serial_host_model(
	// Serial pins
	output logic serial_clk,
	output logic serial_data,
	output logic load_strobe
);
	initial begin
		serial_clk = 1'b0;
		serial_data = 1'b0;
		load_strobe = 1'b0;
	end
	// Clock rests low between words
	task automatic send(input logic [23:0] w);
		for (int i = 23; i >= 0; i--) begin
			serial_data = w[i];
			#160 serial_clk = 1'b1;
			#160 serial_clk = 1'b0;
		end
		// Released data must not look stable
		serial_data = ~serial_data;
		#160 load_strobe = 1'b1;
		#320 load_strobe = 1'b0;
		#160;
	endtask : send
endmodule : serial_host_model

// File: tb/three_wire_config_loader_monitor.sv
// Port checker for the loader
`timescale 1ns/100ps
module three_wire_config_loader_monitor(
	// Clock and reset
	input logic core_clk, sys_rst,
	// Causes
	input logic chip_enable, lock_detect, load_strobe,
	// Effects
	input logic monitor_output, powered_up,
	input logic [95:0] latch_bus
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	pwr_off_a: assert property (!chip_enable[*4] |=> !powered_up)
		else $error("powered while off");
	pwr_on_a: assert property ((chip_enable && latch_bus[21:20] == 2'h0)[*5] |=> powered_up || latch_bus[21:20] != 2'h0)
		else $error("no power up");
	mon_low_a: assert property (latch_bus[3:2] == 2'h3 |-> !monitor_output)
		else $error("monitor not low");
	mon_lock_a: assert property ((latch_bus[3:2] == 2'h0 && lock_detect)[*4] |=> monitor_output || latch_bus[3:2] != 2'h0)
		else $error("lock not shown");
	latch_hold_a: assert property (!load_strobe[*8] |=> $stable(latch_bus))
		else $error("latch moved");
	lane_sel_a: assert property (latch_bus[95:72] != $past(latch_bus[95:72])
		|-> latch_bus[73:72] == 2'h3) else $error("wrong lane");
	cover property (powered_up);
	cover property (monitor_output);
	cover property (latch_bus[95:72] != 24'h00_0000);
endmodule : three_wire_config_loader_monitor
bind three_wire_config_loader three_wire_config_loader_monitor u_mon(.core_clk, .sys_rst,
	.chip_enable, .lock_detect, .load_strobe, .monitor_output, .powered_up, .latch_bus);

// File: tb/three_wire_config_loader_tb.sv
// Self-checking bench for the loader
`timescale 1ns/100ps
module three_wire_config_loader_tb;
	import config_loader_pkg::*;
	logic core_clk = 0, sys_rst = 1, chip_enable = 0, clk_en = 1;
	logic lock_detect = 0, rf_scaled = 0, ref_scaled = 0;
	logic serial_clk, serial_data, load_strobe, monitor_output, powered_up, cp_enable;
	logic [LATCH_COUNT*WORD_WIDTH-1:0] latch_bus;
	int n_fail = 0;
	int n_checks = 0;
	always #20 core_clk = ~core_clk;
	serial_host_model u_host(.serial_clk, .serial_data, .load_strobe);
	three_wire_config_loader u_dut(.core_clk, .sys_rst, .clk_en, .serial_clk,
		.serial_data, .load_strobe, .chip_enable, .lock_detect, .rf_scaled, .ref_scaled,
		.monitor_output, .powered_up, .cp_enable, .latch_bus);
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tick
	task automatic chk_w(input word_type got, input word_type exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_w
	task automatic t_latches();
		word_type w [4] = '{24'h00_000C, 24'h5A_C3_A5, 24'h81_7E_0E, 24'hC3_5A_F3};
		for (int i = 3; i >= 0; i--) u_host.send(w[i]);
		tick(1);
		for (int i = 0; i < 4; i++) chk_w(latch_bus[i*24 +: 24], w[i]);
	endtask : t_latches
	task automatic t_freeze();
		clk_en = 0;
		u_host.send(24'hFF_FFF5);
		clk_en = 1;
		tick(6);
		chk_w(latch_bus[24 +: 24], 24'h5A_C3A5);
	endtask : t_freeze
	task automatic t_power();
		chip_enable = 1;
		tick(6);
		chk_w({22'h0, powered_up, cp_enable}, 24'h00_0003);
		chip_enable = 0;
		tick(6);
		chk_w({22'h0, powered_up, cp_enable}, 24'h00_0000);
		chip_enable = 1;
		u_host.send(24'h30_000C);
		tick(6);
		chk_w({22'h0, powered_up, cp_enable}, 24'h00_0000);
	endtask : t_power
	task automatic t_monitor();
		for (int s = 0; s < 4; s++) begin
			u_host.send({20'h0_0000, s[1:0], 2'h0});
			tick(1);
			for (int v = 0; v < 2; v++) begin
				{lock_detect, rf_scaled, ref_scaled} = v ? 3'h2 : 3'h5;
				tick(6);
				chk_w({23'h0, monitor_output}, {23'h0, s != 3 && ((s == 1) == (v == 1))});
			end
		end
	endtask : t_monitor
	task automatic report_and_stop();
		if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	initial begin
		tick(5);
		sys_rst = 0;
		t_latches();
		t_freeze();
		t_power();
		t_monitor();
		report_and_stop();
	end
	// Run needs about 87 us
	initial begin
		#300_000;
		n_fail++;
		report_and_stop();
	end
endmodule : three_wire_config_loader_tb
